//--- hdl/dps_pkg.sv
// package for the dual slot power switch control block
package dps_pkg;
    // ************************************************
    // timing and layout constants
    // ************************************************
    localparam int unsigned CLK_MHZ = 200;
    localparam int unsigned SETTLE_US = 100;
    localparam int unsigned SETTLE_CYC = SETTLE_US * CLK_MHZ;
    localparam int unsigned SETTLE_W = 15;
    localparam int unsigned TRIP_W = 16;
    localparam logic [TRIP_W-1:0] TRIP_DELAY_RST = 16'h00c8;
    localparam int unsigned CTRL_FORCE_MASK_BIT = 2;
    localparam int unsigned CS_IRQ_MASK_BIT = 3;
    localparam int unsigned CS_SPARE_A_BIT = 4;
    localparam int unsigned CS_SPARE_B_BIT = 5;
    localparam logic [7:0] CS_RST = 8'h00;
    localparam logic [7:0] CTRL_RST = 8'h00;

    // per-slot sense inputs
    typedef struct packed {
        logic hv_limit;
        logic lv_limit;
        logic aux_limit;
        logic aux_short;
        logic hv_uv;
        logic lv_uv;
        logic over_temp;
        logic aux_over_temp;
    } dps_sense_t;

    // per-slot true supply status
    typedef struct packed {
        logic hv_on;
        logic lv_on;
        logic aux_on;
        logic main_fault;
        logic aux_fault;
        logic trip_main_evt;
        logic trip_aux_evt;
    } dps_stat_t;

    typedef struct packed {
        logic main_en_q;
        logic aux_en_q;
        logic main_on;
        logic aux_on;
        logic hv_flt;
        logic lv_flt;
        logic aux_flt;
        logic main_evt;
        logic aux_evt;
        logic [TRIP_W-1:0] main_tmr;
        logic [TRIP_W-1:0] aux_tmr;
    } dps_slot_t;

    typedef enum logic [1:0] {
        ST_WAIT_STBY = 2'b00,
        ST_SETTLE = 2'b01,
        ST_READY = 2'b11
    } dps_pwr_st_t;
endpackage

//--- hdl/dps_ctrl.sv
// dual slot hot-plug power switch control logic
`timescale 1ns/10ps
// ************************************************
// Behaviour
// - main enable rising edge turns main rails on, enable low turns them off
// - aux enable rising edge turns aux rail on, enable low turns it off
// - ignore turn-on before standby valid, settled
// - main enable low clears main faults
// - aux enable low clears aux fault
// - trip flag asserted on breaker trip
// - trip flag holds until all causes cleared
// - power ok only when commanded on, delivering
// - override forces rails on, bypasses protection except main overtemp, which still latches a main fault
// - override keeps standby lockout on aux
// - override releases power ok and trip flag
// - status reports true supply state
// - control bit two masks override
// - spare inputs read at status bits four-five
// - trip timer trips breaker after delay
// - high rail trip drives gate high
// - low rail trip drives gate low
// - main fault shuts both main rails
// - aux off until standby above lockout
// - aux limited, fault latched separately
// - interrupt on fault unless mask set
// - write one to fault bit clears interrupt
// ************************************************
module dps_ctrl (
    input wire logic REF_CLK_I,
    input wire logic RSTN_I,
    input wire logic STANDBY_RAIL_OK_I,
    input wire logic [1:0] MAIN_RAIL_ENABLE_IN_I,
    input wire logic [1:0] AUX_RAIL_ENABLE_IN_I,
    input wire logic [1:0] FORCE_ON_N_I,
    input wire dps_pkg::dps_sense_t [1:0] SENSE_I,
    input wire logic [1:0][7:0] SLOT_CONTROL_REG_I,
    input wire logic [1:0][dps_pkg::TRIP_W-1:0] TRIP_DELAY_I,
    input wire logic IRQ_MASK_BIT_I,
    input wire logic [1:0] FAULT_ACK_I,
    input wire logic SPARE_INPUT_A_I,
    input wire logic SPARE_INPUT_B_I,
    output logic [1:0] HV_GATE_CTRL_O,
    output logic [1:0] LV_GATE_CTRL_O,
    output logic [1:0] AUX_RAIL_OUT_O,
    output logic [1:0] SLOT_POWER_OK_N_O,
    output logic [1:0] SLOT_POWER_OK_N_OE_O,
    output logic [1:0] SLOT_TRIP_N_O,
    output logic [1:0] SLOT_TRIP_N_OE_O,
    output logic IRQ_N_O,
    output logic IRQ_N_OE_O,
    output dps_pkg::dps_stat_t [1:0] SLOT_STATUS_O,
    output logic [7:0] COMMON_STATUS_O
);
    // ************************************************
    // state
    // ************************************************
    typedef struct packed {
        dps_pkg::dps_pwr_st_t pwr;
        logic [dps_pkg::SETTLE_W-1:0] settle;
        dps_pkg::dps_slot_t [1:0] slot;
        logic [1:0] hv_gate;
        logic [1:0] lv_gate;
        logic [1:0] aux_out;
        logic [1:0] pok_oe;
        logic [1:0] trip_oe;
        logic irq_oe;
        dps_pkg::dps_stat_t [1:0] stat;
        logic [7:0] cs;
    } dps_state_t;

    dps_state_t st_ff;
    dps_state_t nxt_st;

    // counts cycles of continuous limit; zero delay trips at once
    function automatic logic [dps_pkg::TRIP_W-1:0] dps_tmr_next(input logic lim,
                                                            input logic [dps_pkg::TRIP_W-1:0] cur,
                                                            input logic [dps_pkg::TRIP_W-1:0] lmt);
        logic [dps_pkg::TRIP_W-1:0] r;
        r = '0;
        if (lim && cur < lmt) begin
            r = cur + 1'b1;
        end else if (lim) begin
            r = cur;
        end
        return r;
    endfunction

    function automatic logic dps_tmr_done(input logic lim,
                                          input logic [dps_pkg::TRIP_W-1:0] cur,
                                          input logic [dps_pkg::TRIP_W-1:0] lmt);
        return lim && (cur >= lmt);
    endfunction

    // main pair conducts only when commanded and no latch is set
    function automatic logic dps_main_up(input dps_pkg::dps_slot_t sl);
        return sl.main_on && !sl.hv_flt && !sl.lv_flt;
    endfunction

    always_comb begin
        logic ready;
        logic forced;
        logic main_rise;
        logic aux_rise;
        logic hv_trip;
        logic lv_trip;
        logic aux_trip;
        logic main_lim;
        logic main_uv;
        logic any_evt;
        logic [dps_pkg::TRIP_W-1:0] dly;
        dps_pkg::dps_sense_t s;
        ready = 1'b0;
        forced = 1'b0;
        main_rise = 1'b0;
        aux_rise = 1'b0;
        hv_trip = 1'b0;
        lv_trip = 1'b0;
        aux_trip = 1'b0;
        main_lim = 1'b0;
        main_uv = 1'b0;
        any_evt = 1'b0;
        dly = '0;
        s = '0;
        nxt_st = st_ff;

        // ************************************************
        // standby validity and settle interval
        // ************************************************
        case (st_ff.pwr)
            dps_pkg::ST_WAIT_STBY: begin
                nxt_st.settle = '0;
                if (STANDBY_RAIL_OK_I) begin
                    nxt_st.pwr = dps_pkg::ST_SETTLE;
                end
            end
            dps_pkg::ST_SETTLE: begin
                nxt_st.settle = st_ff.settle + 1'b1;
                if (!STANDBY_RAIL_OK_I) begin
                    nxt_st.pwr = dps_pkg::ST_WAIT_STBY;
                end else if (st_ff.settle == dps_pkg::SETTLE_W'(dps_pkg::SETTLE_CYC - 1)) begin
                    nxt_st.pwr = dps_pkg::ST_READY;
                end
            end
            dps_pkg::ST_READY: begin
                if (!STANDBY_RAIL_OK_I) begin
                    nxt_st.pwr = dps_pkg::ST_WAIT_STBY;
                end
            end
            default: begin
                nxt_st.pwr = dps_pkg::ST_WAIT_STBY;
            end
        endcase
        ready = (st_ff.pwr == dps_pkg::ST_READY);

        // ************************************************
        // per-slot control
        // ************************************************
        for (int i = 0; i < 2; i++) begin
            s = SENSE_I[i];
            dly = TRIP_DELAY_I[i];
            // masked override has no effect at all
            forced = !FORCE_ON_N_I[i] && !SLOT_CONTROL_REG_I[i][dps_pkg::CTRL_FORCE_MASK_BIT];
            nxt_st.slot[i].main_en_q = MAIN_RAIL_ENABLE_IN_I[i];
            nxt_st.slot[i].aux_en_q = AUX_RAIL_ENABLE_IN_I[i];
            main_rise = MAIN_RAIL_ENABLE_IN_I[i] && !st_ff.slot[i].main_en_q;
            aux_rise = AUX_RAIL_ENABLE_IN_I[i] && !st_ff.slot[i].aux_en_q;

            // edges before settle are dropped, not deferred
            if (main_rise && ready && !st_ff.slot[i].hv_flt && !st_ff.slot[i].lv_flt) begin
                nxt_st.slot[i].main_on = 1'b1;
            end
            if (!MAIN_RAIL_ENABLE_IN_I[i]) begin
                nxt_st.slot[i].main_on = 1'b0;
            end
            if (aux_rise && ready && !st_ff.slot[i].aux_flt) begin
                nxt_st.slot[i].aux_on = 1'b1;
            end
            if (!AUX_RAIL_ENABLE_IN_I[i]) begin
                nxt_st.slot[i].aux_on = 1'b0;
            end

            // one timer per slot group, restarts on leaving limit
            main_lim = s.hv_limit || s.lv_limit;
            nxt_st.slot[i].main_tmr = dps_tmr_next(main_lim && !forced, st_ff.slot[i].main_tmr, dly);
            nxt_st.slot[i].aux_tmr = dps_tmr_next(s.aux_limit && !forced, st_ff.slot[i].aux_tmr, dly);
            main_uv = (s.hv_uv || s.lv_uv) && !forced;
            hv_trip = st_ff.slot[i].main_on && dps_tmr_done(s.hv_limit && !forced, st_ff.slot[i].main_tmr, dly);
            lv_trip = st_ff.slot[i].main_on && dps_tmr_done(s.lv_limit && !forced, st_ff.slot[i].main_tmr, dly);
            // uv and overtemp act at once, only current limit is filtered
            hv_trip = hv_trip || (st_ff.slot[i].main_on && (main_uv || s.over_temp));
            lv_trip = lv_trip || (st_ff.slot[i].main_on && (main_uv || s.over_temp));
            aux_trip = st_ff.slot[i].aux_on && !forced
                       && (dps_tmr_done(s.aux_limit, st_ff.slot[i].aux_tmr, dly)
                           || s.aux_short || s.aux_over_temp);
            // any main fault shuts both main rails
            if (hv_trip || lv_trip) begin
                nxt_st.slot[i].hv_flt = hv_trip || st_ff.slot[i].hv_flt;
                nxt_st.slot[i].lv_flt = lv_trip || st_ff.slot[i].lv_flt;
                nxt_st.slot[i].main_on = 1'b0;
                nxt_st.slot[i].main_evt = 1'b1;
            end else if (!MAIN_RAIL_ENABLE_IN_I[i]) begin
                nxt_st.slot[i].hv_flt = 1'b0;
                nxt_st.slot[i].lv_flt = 1'b0;
            end
            if (aux_trip) begin
                nxt_st.slot[i].aux_flt = 1'b1;
                nxt_st.slot[i].aux_on = 1'b0;
                nxt_st.slot[i].aux_evt = 1'b1;
            end else if (!AUX_RAIL_ENABLE_IN_I[i]) begin
                nxt_st.slot[i].aux_flt = 1'b0;
            end
            // write-one ack; a new event in the same cycle wins
            if (FAULT_ACK_I[i] && !(hv_trip || lv_trip)) begin
                nxt_st.slot[i].main_evt = 1'b0;
            end
            if (FAULT_ACK_I[i] && !aux_trip) begin
                nxt_st.slot[i].aux_evt = 1'b0;
            end

            // standby loss is a power cycle: no request or latch survives it
            if (st_ff.pwr == dps_pkg::ST_WAIT_STBY) begin
                nxt_st.slot[i].main_on = 1'b0;
                nxt_st.slot[i].aux_on = 1'b0;
                nxt_st.slot[i].hv_flt = 1'b0;
                nxt_st.slot[i].lv_flt = 1'b0;
                nxt_st.slot[i].aux_flt = 1'b0;
                nxt_st.slot[i].main_evt = 1'b0;
                nxt_st.slot[i].aux_evt = 1'b0;
                nxt_st.slot[i].main_tmr = '0;
                nxt_st.slot[i].aux_tmr = '0;
            end

            // ************************************************
            // pins
            // ************************************************
            // high rail gate is off when high, low rail gate off when low
            nxt_st.hv_gate[i] = !(dps_main_up(nxt_st.slot[i]) || forced);
            nxt_st.lv_gate[i] = dps_main_up(nxt_st.slot[i]) || forced;
            // aux never bypasses standby lockout, even under override
            nxt_st.aux_out[i] = STANDBY_RAIL_OK_I
                                && ((nxt_st.slot[i].aux_on && !nxt_st.slot[i].aux_flt) || forced);
            // oe low means pin pulled low (asserted)
            nxt_st.pok_oe[i] = forced || !(nxt_st.slot[i].main_on && nxt_st.slot[i].aux_on
                                           && !nxt_st.hv_gate[i] && nxt_st.lv_gate[i]
                                           && nxt_st.aux_out[i]);
            nxt_st.trip_oe[i] = forced || !(nxt_st.slot[i].hv_flt || nxt_st.slot[i].lv_flt
                                            || nxt_st.slot[i].aux_flt);

            // true supply state, regardless of override pin drive
            nxt_st.stat[i].hv_on = !nxt_st.hv_gate[i];
            nxt_st.stat[i].lv_on = nxt_st.lv_gate[i];
            nxt_st.stat[i].aux_on = nxt_st.aux_out[i];
            nxt_st.stat[i].main_fault = nxt_st.slot[i].hv_flt || nxt_st.slot[i].lv_flt;
            nxt_st.stat[i].aux_fault = nxt_st.slot[i].aux_flt;
            nxt_st.stat[i].trip_main_evt = nxt_st.slot[i].main_evt;
            nxt_st.stat[i].trip_aux_evt = nxt_st.slot[i].aux_evt;
            any_evt = any_evt || nxt_st.slot[i].main_evt || nxt_st.slot[i].aux_evt;
        end

        // ************************************************
        // common status and interrupt
        // ************************************************
        // rebuilt every cycle, unused bits read zero
        nxt_st.cs = dps_pkg::CS_RST;
        nxt_st.cs[dps_pkg::CS_IRQ_MASK_BIT] = IRQ_MASK_BIT_I;
        nxt_st.cs[dps_pkg::CS_SPARE_A_BIT] = SPARE_INPUT_A_I;
        nxt_st.cs[dps_pkg::CS_SPARE_B_BIT] = SPARE_INPUT_B_I;
        nxt_st.irq_oe = !(any_evt && !IRQ_MASK_BIT_I);
    end

    // ************************************************
    // registers
    // ************************************************
    // open-drain flags come out of reset released, gates off
    always_ff @(posedge REF_CLK_I) begin
        if (!RSTN_I) begin
            st_ff <= '0;
            st_ff.pwr <= dps_pkg::ST_WAIT_STBY;
            st_ff.hv_gate <= 2'h3;
            st_ff.pok_oe <= 2'h3;
            st_ff.trip_oe <= 2'h3;
            st_ff.irq_oe <= 1'b1;
            st_ff.cs <= dps_pkg::CS_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign HV_GATE_CTRL_O = st_ff.hv_gate;
    assign LV_GATE_CTRL_O = st_ff.lv_gate;
    assign AUX_RAIL_OUT_O = st_ff.aux_out;
    assign SLOT_POWER_OK_N_O = 2'h0;
    assign SLOT_POWER_OK_N_OE_O = st_ff.pok_oe;
    assign SLOT_TRIP_N_O = 2'h0;
    assign SLOT_TRIP_N_OE_O = st_ff.trip_oe;
    assign IRQ_N_O = 1'b0;
    assign IRQ_N_OE_O = st_ff.irq_oe;
    assign SLOT_STATUS_O = st_ff.stat;
    assign COMMON_STATUS_O = st_ff.cs;
endmodule

//--- tb/dps_slot_mdl.sv
// load model of one plug-in card slot
`timescale 1ns/10ps
module dps_slot_mdl (
    input wire logic hv_gate_i,
    input wire logic lv_gate_i,
    input wire logic aux_i,
    input wire logic hv_load_i,
    input wire logic aux_load_i,
    output dps_pkg::dps_sense_t sense_o
);
    // overload shows only while the rail really carries power
    always_comb begin
        sense_o = '0;
        sense_o.hv_limit = hv_load_i && !hv_gate_i && lv_gate_i;
        sense_o.aux_limit = aux_load_i && aux_i;
    end
endmodule

//--- tb/dps_ctrl_checker.sv
// port assertions for the dual slot power switch control
`timescale 1ns/10ps
module dps_ctrl_checker (
    input wire logic REF_CLK_I,
    input wire logic RSTN_I,
    input wire logic STANDBY_RAIL_OK_I,
    input wire logic [1:0] MAIN_RAIL_ENABLE_IN_I,
    input wire logic [1:0] FORCE_ON_N_I,
    input wire logic [1:0][7:0] SLOT_CONTROL_REG_I,
    input wire logic IRQ_MASK_BIT_I,
    input wire logic SPARE_INPUT_A_I,
    input wire logic SPARE_INPUT_B_I,
    input wire logic [1:0] HV_GATE_CTRL_O,
    input wire logic [1:0] LV_GATE_CTRL_O,
    input wire logic [1:0] AUX_RAIL_OUT_O,
    input wire logic [1:0] SLOT_POWER_OK_N_OE_O,
    input wire logic [1:0] SLOT_TRIP_N_OE_O,
    input wire dps_pkg::dps_stat_t [1:0] SLOT_STATUS_O,
    input wire logic [7:0] COMMON_STATUS_O
);
    default clocking @(posedge REF_CLK_I); endclocking
    default disable iff (!RSTN_I);
    AST_SPARE: assert property ($past(RSTN_I) |-> COMMON_STATUS_O[5:4] == $past({SPARE_INPUT_B_I, SPARE_INPUT_A_I}))
        else $error("spare input status bits wrong");
    AST_IRQ_MASK: assert property ($past(RSTN_I) |-> COMMON_STATUS_O[3] == $past(IRQ_MASK_BIT_I))
        else $error("mask bit mirror wrong");
    // ************************
    // per slot
    // ************************
    for (genvar s = 0; s < 2; s++) begin : g_slot
        // override as it should act, with the mask bit applied
        wire ovr = !FORCE_ON_N_I[s] && !SLOT_CONTROL_REG_I[s][dps_pkg::CTRL_FORCE_MASK_BIT];
        AST_EDGE: assert property ($fell(HV_GATE_CTRL_O[s]) && !$past(ovr) |->
            $past(MAIN_RAIL_ENABLE_IN_I[s]) && !$past(MAIN_RAIL_ENABLE_IN_I[s], 2))
            else $error("main rail on without enable edge");
        AST_PWR_OK: assert property (!SLOT_POWER_OK_N_OE_O[s] |-> !HV_GATE_CTRL_O[s] && LV_GATE_CTRL_O[s] && AUX_RAIL_OUT_O[s])
            else $error("power ok while a rail is off");
        AST_TRIP_FLAG: assert property (!SLOT_TRIP_N_OE_O[s] |-> SLOT_STATUS_O[s].main_fault || SLOT_STATUS_O[s].aux_fault)
            else $error("trip flag without latched fault");
        AST_CROSS: assert property (!ovr && !$past(ovr) |-> HV_GATE_CTRL_O[s] == !LV_GATE_CTRL_O[s])
            else $error("main rails out of step");
        AST_OVR_ON: assert property ($past(ovr) |-> !HV_GATE_CTRL_O[s] ##0 LV_GATE_CTRL_O[s])
            else $error("override did not force main rails");
        AST_OVR_REL: assert property ($past(ovr) |-> SLOT_POWER_OK_N_OE_O[s] && SLOT_TRIP_N_OE_O[s])
            else $error("flags driven during override");
        AST_AUX_UVLO: assert property (!STANDBY_RAIL_OK_I |=> !AUX_RAIL_OUT_O[s])
            else $error("aux rail on without standby");
    end
endmodule

//--- tb/tb.sv
// testbench for the dual slot power switch control
`timescale 1ns/10ps
module tb;
    typedef struct packed {logic a; logic b; logic m; logic [7:0] e;} dps_row_t;
    logic clk = 1'h0, rstn = 1'h0, stby = 1'h0, irqm = 1'h0, spa = 1'h0, spb = 1'h0;
    logic [1:0] men = 2'h0, aen = 2'h0, fon = 2'h3, ack = 2'h0, ovl = 2'h0, aovl = 2'h0;
    logic [1:0][7:0] ctl = '0;
    logic [1:0][dps_pkg::TRIP_W-1:0] dly = {16'h0003, 16'h0003};
    wire dps_pkg::dps_sense_t [1:0] sns;
    logic [1:0] hv, lv, aux, pok, pokoe, trp, trpoe;
    logic irq, irqoe;
    logic [7:0] cs;
    dps_pkg::dps_stat_t [1:0] st;
    int n_fail = 0, cmp_count = 0;
    dps_row_t rows [4] = '{'{1'h0, 1'h0, 1'h0, 8'h00}, '{1'h1, 1'h0, 1'h0, 8'h10},
        '{1'h0, 1'h1, 1'h0, 8'h20}, '{1'h1, 1'h1, 1'h1, 8'h38}};
    initial forever #2.5 clk = ~clk;
    dps_ctrl dut (.REF_CLK_I(clk), .RSTN_I(rstn), .STANDBY_RAIL_OK_I(stby), .MAIN_RAIL_ENABLE_IN_I(men),
        .AUX_RAIL_ENABLE_IN_I(aen), .FORCE_ON_N_I(fon), .SENSE_I(sns), .SLOT_CONTROL_REG_I(ctl),
        .TRIP_DELAY_I(dly), .IRQ_MASK_BIT_I(irqm), .FAULT_ACK_I(ack), .SPARE_INPUT_A_I(spa),
        .SPARE_INPUT_B_I(spb), .HV_GATE_CTRL_O(hv), .LV_GATE_CTRL_O(lv), .AUX_RAIL_OUT_O(aux),
        .SLOT_POWER_OK_N_O(pok), .SLOT_POWER_OK_N_OE_O(pokoe), .SLOT_TRIP_N_O(trp),
        .SLOT_TRIP_N_OE_O(trpoe), .IRQ_N_O(irq), .IRQ_N_OE_O(irqoe), .SLOT_STATUS_O(st),
        .COMMON_STATUS_O(cs));
    for (genvar s = 0; s < 2; s++) begin : g_card
        dps_slot_mdl u_card (.hv_gate_i(hv[s]), .lv_gate_i(lv[s]), .aux_i(aux[s]),
            .hv_load_i(ovl[s]), .aux_load_i(aovl[s]), .sense_o(sns[s]));
    end
    task chk(input string nm, input logic [7:0] s, input logic [7:0] e);
        cmp_count++;
        if (s !== e) begin
            n_fail++;
            $display("BAD %s exp %h got %h", nm, e, s);
        end
    endtask
    task tick(input int n);
        repeat (n) @(negedge clk);
    endtask
    task print_verdict;
        $display("checks %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // ************************
    // main sequence
    // ************************
    initial begin
        int k;
        tick(4);
        chk("reset_rails", {hv, lv, aux, pokoe}, 8'hc3);
        chk("reset_flags", {trpoe, irqoe}, 8'h07);
        chk("pin_data", {pok, trp, irq}, 8'h00);
        rstn = 1'h1;
        stby = 1'h1;
        men[0] = 1'h1;
        tick(3);
        chk("early_enable", hv[0], 8'h01);
        men[0] = 1'h0;
        tick(dps_pkg::SETTLE_CYC + 4);
        chk("edge_dropped", hv[0], 8'h01);
        foreach (rows[i]) begin
            {spa, spb, irqm} = {rows[i].a, rows[i].b, rows[i].m};
            tick(2);
            chk("common_status", cs, rows[i].e);
        end
        irqm = 1'h0;
        men = 2'h3;
        aen = 2'h3;
        tick(2);
        chk("both_on", {hv, lv, aux, pokoe}, 8'h3c);
        aen[1] = 1'h0;
        tick(2);
        chk("aux_off", {hv, lv, aux, pokoe}, 8'h36);
        // two short bursts below the delay must not trip
        ovl[0] = 1'h1;
        tick(2);
        ovl[0] = 1'h0;
        tick(1);
        ovl[0] = 1'h1;
        tick(2);
        ovl[0] = 1'h0;
        tick(2);
        chk("burst_no_trip", {trpoe[0], hv[0]}, 8'h02);
        ovl[0] = 1'h1;
        k = 0;
        while (trpoe[0] !== 1'h0 && k < 20) begin
            tick(1);
            k++;
        end
        ovl[0] = 1'h0;
        chk("trip_delay", (k >= 4 && k <= 5), 8'h01);
        tick(1);
        chk("trip_rails", {hv, lv}, 8'h06);
        chk("trip_stat", {st[0].main_fault, st[0].trip_main_evt, irqoe}, 8'h06);
        men[0] = 1'h0;
        tick(2);
        chk("main_clear", {trpoe[0], st[0].main_fault}, 8'h02);
        ack = 2'h1;
        tick(1);
        ack = 2'h0;
        tick(2);
        chk("irq_ack", irqoe, 8'h01);
        aen[1] = 1'h1;
        aovl[1] = 1'h1;
        k = 0;
        while (trpoe[1] !== 1'h0 && k < 20) begin
            tick(1);
            k++;
        end
        aovl[1] = 1'h0;
        tick(1);
        chk("aux_trip", {aux[1], lv[1], st[1].aux_fault, st[1].main_fault}, 8'h06);
        chk("aux_trip_evt", {st[1].trip_aux_evt, irqoe}, 8'h02);
        aen[1] = 1'h0;
        tick(2);
        chk("aux_clear", {trpoe[1], st[1].aux_fault}, 8'h02);
        irqm = 1'h1;
        tick(2);
        chk("irq_masked", irqoe, 8'h01);
        irqm = 1'h0;
        tick(2);
        chk("irq_unmasked", irqoe, 8'h00);
        ack = 2'h2;
        tick(1);
        ack = 2'h0;
        tick(2);
        chk("aux_ack", {st[1].trip_aux_evt, irqoe}, 8'h01);
        fon[0] = 1'h0;
        tick(2);
        chk("override", {hv[0], lv[0], aux[0], pokoe[0], trpoe[0]}, 8'h0f);
        chk("override_stat", {st[0].hv_on, st[0].lv_on, st[0].main_fault}, 8'h06);
        ctl[0][dps_pkg::CTRL_FORCE_MASK_BIT] = 1'h1;
        tick(2);
        chk("override_mask", {hv[0], lv[0]}, 8'h02);
        fon[0] = 1'h1;
        ctl[0] = 8'h00;
        stby = 1'h0;
        tick(2);
        chk("aux_uvlo", aux, 8'h00);
        chk("stby_loss_rails", {hv, lv}, 8'h0c);
        print_verdict();
    end
    initial begin
        #150us;
        n_fail++;
        print_verdict();
    end
endmodule
bind dps_ctrl dps_ctrl_checker u_chk (.REF_CLK_I, .RSTN_I, .STANDBY_RAIL_OK_I, .MAIN_RAIL_ENABLE_IN_I,
    .FORCE_ON_N_I, .SLOT_CONTROL_REG_I, .IRQ_MASK_BIT_I, .SPARE_INPUT_A_I, .SPARE_INPUT_B_I,
    .HV_GATE_CTRL_O, .LV_GATE_CTRL_O, .AUX_RAIL_OUT_O, .SLOT_POWER_OK_N_OE_O, .SLOT_TRIP_N_OE_O,
    .SLOT_STATUS_O, .COMMON_STATUS_O);
